// *** logic/pam_pkg.sv ***
// Purpose: constants shared by the port A pin multiplexer
// Assumes: 32 lines, up to two peripheral functions per line
// Notes:   line numbers name function A, function B in the comment
package pam_pkg;

    localparam int          PAM_LINES          = 32;

    // lines that own a function B; lines 6 to 9 and 13 have none
    localparam logic [31:0] PAM_B_PRESENT      = 32'hFFFF_DC3F;
    localparam logic [31:0] PAM_A_PRESENT      = 32'hFFFF_FFFF;

    // reset state of each line: 1 = assigned to a peripheral at reset
    localparam logic [31:0] PAM_RESET_PERIPH   = 32'h0000_0000;
    // reset function for peripheral lines: 1 = function B
    localparam logic [31:0] PAM_RESET_B_SEL    = 32'h0000_0000;
    // pull-ups are on for every line after reset
    localparam logic [31:0] PAM_RESET_PULLUP   = 32'hFFFF_FFFF;
    localparam logic [31:0] PAM_RESET_GPIO_OE  = 32'h0000_0000;
    localparam logic [31:0] PAM_RESET_GPIO_OUT = 32'h0000_0000;
    localparam logic [31:0] PAM_RESET_PAD_OE_N = 32'hFFFF_FFFF;
    localparam logic [31:0] PAM_RESET_PAD_OUT  = 32'h0000_0000;

    // pad input synchroniser depth
    localparam int          PAM_SYNC_STAGES    = 2;

    localparam int LINE_SDCARD0_DATA0          = 0;  // spi0 miso
    localparam int LINE_SDCARD0_CMD            = 1;  // spi0 mosi
    localparam int LINE_SDCARD0_CLK            = 2;  // spi0 spck
    localparam int LINE_SDCARD0_DATA1          = 3;  // spi0_cs1
    localparam int LINE_SDCARD0_DATA2          = 4;  // spi0_cs2
    localparam int LINE_SDCARD0_DATA3          = 5;  // spi0_cs0
    localparam int LINE_AUDIO_CODEC_FRAME_SYNC = 6;  // none
    localparam int LINE_AUDIO_CODEC_CLOCK      = 7;  // none
    localparam int LINE_AUDIO_CODEC_TX         = 8;  // none
    localparam int LINE_AUDIO_CODEC_RX         = 9;  // none
    localparam int LINE_EXT_INT0               = 10; // pulse_out1
    localparam int LINE_DMA_REQUEST0           = 11; // pulse_out3
    localparam int LINE_CAN_TRANSMIT           = 12; // prog_clock_out0
    localparam int LINE_CAN_RECEIVE            = 13; // none
    localparam int LINE_TIMER_EXT_CLOCK2       = 14; // ext_int1
    localparam int LINE_DMA_REQUEST3           = 15; // prog_clock_out2
    localparam int LINE_SDCARD1_CLK            = 16; // camera_data0
    localparam int LINE_SDCARD1_CMD            = 17; // camera_data1
    localparam int LINE_SDCARD1_DATA0          = 18; // camera_data2
    localparam int LINE_SDCARD1_DATA1          = 19; // camera_data3
    localparam int LINE_SDCARD1_DATA2          = 20; // camera_data4
    localparam int LINE_SDCARD1_DATA3          = 21; // camera_data5
    localparam int LINE_USART0_TX              = 22; // camera_data6
    localparam int LINE_USART0_RX              = 23; // camera_data7
    localparam int LINE_USART0_REQUEST_TO_SEND = 24; // camera_pixel_clock
    localparam int LINE_USART0_CLEAR_TO_SEND   = 25; // camera_hsync
    localparam int LINE_USART0_SERIAL_CLOCK    = 26; // camera_vsync
    localparam int LINE_PROG_CLOCK_OUT1        = 27; // camera_master_clock
    localparam int LINE_SPI0_CS3               = 28; // camera_data8
    localparam int LINE_TIMER0_IO_A            = 29; // camera_data9
    localparam int LINE_TIMER0_IO_B            = 30; // camera_data10
    localparam int LINE_DMA_REQUEST1           = 31; // camera_data11

endpackage

// *** logic/pam_pin_sync.sv ***
// Purpose: two-flop synchroniser for the pad input levels
// Assumes: pads are asynchronous to clk
// Notes:   first stage is read only by the second stage
module pam_pin_sync
    import pam_pkg::*;
#(
    parameter int WIDTH = PAM_LINES
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    always_comb
    begin
        next_meta     = meta;
        next_sync_out = sync_out;
        if (ce)
        begin
            next_meta     = async_in;
            next_sync_out = meta;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule

// *** logic/pam_port_a_mux.sv ***
// Purpose: pin multiplexer of port_a, gpio or peripheral A/B per line
// Assumes: config strobes and peripheral signals are on clk
// Notes:   pad outputs are registered, pad inputs pass two flops
//
// Operation
// - Each of the 32 lines goes to gpio or to exactly one of function A or B.
// - Every line leaves reset as an undriven input with its pull-up on.
// - A line that resets as gpio shows zero in peripheral_select_status.
// - A line that resets to a peripheral shows one in status and keeps its pull-up on.
// - Lines 0 to 5 carry sdcard0 signals as A and the first spi port as B.
// - Lines 10 to 15 carry interrupt, dma, can, timer and clock signals as A/B.
// - Lines 16 to 21 carry sdcard1 as A and camera data 0 to 5 as B.
// - Lines 22 to 27 carry usart0 and prog_clock_out1 as A and camera signals as B.
// - Lines 28 to 31 carry spi0_cs3, timer0 and dma_request1 as A and camera data as B.
// - An output offered on several lines is driven on every line that selects it.
module pam_port_a_mux
    import pam_pkg::*;
#(
    parameter logic [31:0] RESET_PERIPH = PAM_RESET_PERIPH,
    parameter logic [31:0] RESET_B_SEL  = PAM_RESET_B_SEL
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // configuration strobes, set wins over clear
    input  wire logic [31:0] periph_set,
    input  wire logic [31:0] periph_clr,
    input  wire logic [31:0] func_b_set,
    input  wire logic [31:0] func_a_set,
    input  wire logic [31:0] pullup_set,
    input  wire logic [31:0] pullup_clr,
    input  wire logic [31:0] gpio_oe_set,
    input  wire logic [31:0] gpio_oe_clr,
    input  wire logic [31:0] gpio_out_set,
    input  wire logic [31:0] gpio_out_clr,
    // peripheral side, indexed by line
    input  wire logic [31:0] func_a_out,
    input  wire logic [31:0] func_a_oe,
    input  wire logic [31:0] func_b_out,
    input  wire logic [31:0] func_b_oe,
    output logic      [31:0] line_level,
    // status
    output logic      [31:0] peripheral_select_status,
    output logic      [31:0] func_b_select,
    output logic      [31:0] gpio_oe_status,
    output logic      [31:0] gpio_out_status,
    // pads
    input  wire logic [31:0] pad_in,
    output logic      [31:0] pad_out,
    output logic      [31:0] pad_oe_n,
    output logic      [31:0] pad_pullup_en
);

    logic [31:0] next_periph;
    logic [31:0] next_b_sel;
    logic [31:0] next_pullup;
    logic [31:0] next_gpio_oe;
    logic [31:0] next_gpio_out;
    logic [31:0] next_pad_out;
    logic [31:0] next_pad_oe_n;

    // pad levels for gpio and every peripheral, selected or not
    pam_pin_sync #(
        .WIDTH    (PAM_LINES)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .async_in (pad_in),
        .sync_out (line_level)
    );

    // configuration state, set overrides clear on the same bit
    always_comb
    begin
        next_periph   = peripheral_select_status;
        next_b_sel    = func_b_select;
        next_pullup   = pad_pullup_en;
        next_gpio_oe  = gpio_oe_status;
        next_gpio_out = gpio_out_status;
        if (ce)
        begin
            next_periph   = (peripheral_select_status & ~periph_clr) | periph_set;
            next_b_sel    = (func_b_select & ~func_a_set) | func_b_set;
            next_pullup   = (pad_pullup_en & ~pullup_clr) | pullup_set;
            next_gpio_oe  = (gpio_oe_status & ~gpio_oe_clr) | gpio_oe_set;
            next_gpio_out = (gpio_out_status & ~gpio_out_clr) | gpio_out_set;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            peripheral_select_status <= RESET_PERIPH;
            func_b_select            <= RESET_B_SEL;
            pad_pullup_en            <= PAM_RESET_PULLUP;
            gpio_oe_status           <= PAM_RESET_GPIO_OE;
            gpio_out_status          <= PAM_RESET_GPIO_OUT;
        end
        else
        begin
            peripheral_select_status <= next_periph;
            func_b_select            <= next_b_sel;
            pad_pullup_en            <= next_pullup;
            gpio_oe_status           <= next_gpio_oe;
            gpio_out_status          <= next_gpio_out;
        end
    end

    // per line output routing
    genvar i;
    generate
        for (i = 0; i < PAM_LINES; i++)
        begin : g_line
            logic line_out;
            logic line_oe_n;

            always_comb
            begin
                line_out  = pad_out[i];
                line_oe_n = pad_oe_n[i];
                if (ce)
                begin
                    line_out  = 1'b0;
                    line_oe_n = 1'b1;
                    if (!peripheral_select_status[i])
                    begin
                        line_out  = gpio_out_status[i];
                        line_oe_n = ~gpio_oe_status[i];
                    end
                    else if (!func_b_select[i])
                    begin
                        if (PAM_A_PRESENT[i])
                        begin
                            line_out  = func_a_out[i];
                            line_oe_n = ~func_a_oe[i];
                        end
                    end
                    else if (PAM_B_PRESENT[i])
                    begin
                        line_out  = func_b_out[i];
                        line_oe_n = ~func_b_oe[i];
                    end
                    // no function B: pad stays undriven
                end
            end

            assign next_pad_out[i]  = line_out;
            assign next_pad_oe_n[i] = line_oe_n;

            AST_GPIO_DRIVE: assert property (@(posedge clk) disable iff (!reset_n)
                (ce && !peripheral_select_status[i])
                |=> (pad_oe_n[i] == !$past(gpio_oe_status[i])) && (pad_out[i] == $past(gpio_out_status[i])))
                else $error("gpio line not driven from gpio state");

            AST_FUNC_A_DRIVE: assert property (@(posedge clk) disable iff (!reset_n)
                (ce && peripheral_select_status[i] && !func_b_select[i])
                |=> (pad_oe_n[i] == !$past(func_a_oe[i])) && (pad_out[i] == $past(func_a_out[i])))
                else $error("function A not routed to its line");

            AST_FUNC_B_DRIVE: assert property (@(posedge clk) disable iff (!reset_n)
                (ce && peripheral_select_status[i] && func_b_select[i] && PAM_B_PRESENT[i])
                |=> (pad_oe_n[i] == !$past(func_b_oe[i])) && (pad_out[i] == $past(func_b_out[i])))
                else $error("function B not routed to its line");

            AST_NO_B_UNDRIVEN: assert property (@(posedge clk) disable iff (!reset_n)
                (ce && peripheral_select_status[i] && func_b_select[i] && !PAM_B_PRESENT[i])
                |=> pad_oe_n[i])
                else $error("line without function B is driven");

            AST_LEVEL_SEEN: assert property (@(posedge clk) disable iff (!reset_n)
                ($past(ce, 1) && $past(ce, 2) && $past(reset_n, 2))
                |-> line_level[i] == $past(pad_in[i], 2))
                else $error("pad level not visible two cycles later");

            AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
                (ce && periph_set[i] && periph_clr[i]) |=> peripheral_select_status[i])
                else $error("peripheral set lost against clear");
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_out  <= PAM_RESET_PAD_OUT;
            pad_oe_n <= PAM_RESET_PAD_OE_N;
        end
        else
        begin
            pad_out  <= next_pad_out;
            pad_oe_n <= next_pad_oe_n;
        end
    end

    AST_RESET_INPUT: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> (pad_pullup_en == PAM_RESET_PULLUP) && ((pad_oe_n | RESET_PERIPH) == 32'hFFFF_FFFF))
        else $error("line not an input with pull-up after reset");

    AST_RESET_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> peripheral_select_status == RESET_PERIPH)
        else $error("peripheral status wrong after reset");

    AST_RESET_PERIPH_PULLUP: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> ((pad_pullup_en & RESET_PERIPH) == RESET_PERIPH))
        else $error("peripheral line lost its pull-up at reset");

    AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
        !ce |=> $stable(pad_out) && $stable(pad_oe_n) && $stable(peripheral_select_status))
        else $error("state moved while clock enable low");

    COV_A_ON_LINE0: cover property (@(posedge clk) disable iff (!reset_n)
        peripheral_select_status[LINE_SDCARD0_DATA0] && !func_b_select[LINE_SDCARD0_DATA0]
        ##1 !pad_oe_n[LINE_SDCARD0_DATA0]);

    COV_B_ON_LINE31: cover property (@(posedge clk) disable iff (!reset_n)
        peripheral_select_status[LINE_DMA_REQUEST1] && func_b_select[LINE_DMA_REQUEST1]
        ##1 !pad_oe_n[LINE_DMA_REQUEST1]);

    COV_GPIO_LINE6: cover property (@(posedge clk) disable iff (!reset_n)
        !peripheral_select_status[LINE_AUDIO_CODEC_FRAME_SYNC] && gpio_oe_status[LINE_AUDIO_CODEC_FRAME_SYNC]);

    COV_EMPTY_B_LINE13: cover property (@(posedge clk) disable iff (!reset_n)
        peripheral_select_status[LINE_CAN_RECEIVE] && func_b_select[LINE_CAN_RECEIVE]);

endmodule

// *** tb/pam_pad_model.sv ***
// Purpose: pads and outside world of port_a, resolving each pad level
// Assumes: the chip wins over an outside driver when both drive
// Notes:   a pad left floating without pull-up wanders every cycle
module pam_pad_model (
    input  wire logic        clk,
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe_n,
    input  wire logic [31:0] pad_pullup_en,
    input  wire logic [31:0] ext_drive,
    input  wire logic [31:0] ext_en,
    output logic      [31:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] wander = 32'h5A5A_A5A5;

    // floating level must not settle to a stale value
    always @(posedge clk)
        wander <= ~wander;

    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_drive)
                  | (pad_oe_n & ~ext_en & (pad_pullup_en | wander));
endmodule

// *** tb/test_port_a_pin_multiplexer.sv ***
// Purpose: self-checking bench of the port_a pin multiplexer
// Assumes: strobes change just after a rising edge, outputs read at falling edge
// Notes:   lines 6 to 9 and 13 have no function B
module test_port_a_pin_multiplexer;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] NO_B = 32'h0000_23C0;
    logic        clk, reset_n, ce;
    logic [31:0] periph_set, periph_clr, func_b_set, func_a_set, pullup_set, pullup_clr;
    logic [31:0] gpio_oe_set, gpio_oe_clr, gpio_out_set, gpio_out_clr;
    logic [31:0] func_a_out, func_a_oe, func_b_out, func_b_oe, ext_drive, ext_en;
    wire  logic [31:0] line_level, peripheral_select_status, func_b_select, gpio_oe_status;
    wire  logic [31:0] gpio_out_status, pad_in, pad_out, pad_oe_n, pad_pullup_en;
    int          mismatches, num_checks, cycles;

    pam_port_a_mux u_pam_port_a_mux (.clk(clk), .reset_n(reset_n), .ce(ce), .periph_set(periph_set),
        .periph_clr(periph_clr), .func_b_set(func_b_set), .func_a_set(func_a_set),
        .pullup_set(pullup_set), .pullup_clr(pullup_clr), .gpio_oe_set(gpio_oe_set),
        .gpio_oe_clr(gpio_oe_clr), .gpio_out_set(gpio_out_set), .gpio_out_clr(gpio_out_clr),
        .func_a_out(func_a_out), .func_a_oe(func_a_oe), .func_b_out(func_b_out), .func_b_oe(func_b_oe),
        .line_level(line_level), .peripheral_select_status(peripheral_select_status),
        .func_b_select(func_b_select), .gpio_oe_status(gpio_oe_status), .gpio_out_status(gpio_out_status),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en));

    pam_pad_model u_pam_pad_model (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .ext_drive(ext_drive), .ext_en(ext_en), .pad_in(pad_in));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // one config pulse, then every strobe back to zero
    task automatic cfg(input logic [31:0] ps, input logic [31:0] pc, input logic [31:0] bs,
                       input logic [31:0] as);
        @(posedge clk);
        periph_set <= ps;
        periph_clr <= pc;
        func_b_set <= bs;
        func_a_set <= as;
        @(posedge clk);
        {periph_set, periph_clr, func_b_set, func_a_set, pullup_set, pullup_clr} <= '0;
        {gpio_oe_set, gpio_oe_clr, gpio_out_set, gpio_out_clr} <= '0;
    endtask

    task automatic t_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        settle(5);
        check("status", peripheral_select_status, 32'h0000_0000);
        check("pullup", pad_pullup_en, 32'hFFFF_FFFF);
        check("oe_n", pad_oe_n, 32'hFFFF_FFFF);
        check("bsel", func_b_select, 32'h0000_0000);
        @(posedge clk);
        reset_n <= 1'b1;
        settle(5);
        check("level", line_level, 32'hFFFF_FFFF);
        $display("test reset done, mismatches %0d", mismatches);
    endtask

    task automatic t_func_a();
        func_a_out <= 32'hA5C3_3C96;
        func_a_oe  <= 32'h0FF0_FFFF;
        cfg(32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF);
        settle(5);
        check("status", peripheral_select_status, 32'hFFFF_FFFF);
        check("pullup", pad_pullup_en, 32'hFFFF_FFFF);
        check("oe_n", pad_oe_n, 32'hF00F_0000);
        check("pad", pad_out & 32'h0FF0_FFFF, 32'h05C0_3C96);
        check("level", line_level, 32'hF5CF_3C96);
        $display("test func_a done, mismatches %0d", mismatches);
    endtask

    task automatic t_func_b();
        func_b_out <= 32'h6B2D_FFFF;
        func_b_oe  <= 32'hFFFF_FFFF;
        ext_en     <= NO_B;
        ext_drive  <= 32'h0000_0140;
        cfg(32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0001);
        settle(5);
        check("bsel", func_b_select, 32'hFFFF_FFFF);
        check("oe_n", pad_oe_n, NO_B);
        check("pad", pad_out & ~NO_B, 32'h6B2D_DC3F);
        check("level", line_level & NO_B, 32'h0000_0140);
        ext_en <= '0;
        $display("test func_b done, mismatches %0d", mismatches);
    endtask

    task automatic t_fanout();
        logic s;
        s = 1'b0;
        cfg(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0800_0000);
        func_a_oe <= 32'hFFFF_FFFF;
        repeat (4)
        begin
            s = ~s;
            @(posedge clk);
            func_b_out[10] <= s;
            func_a_out[27] <= s;
            settle(2);
            check("fanout", {30'h0, pad_out[27], pad_out[10]}, {30'h0, s, s});
        end
        $display("test fanout done, mismatches %0d", mismatches);
    endtask

    task automatic t_gpio();
        @(posedge clk);
        gpio_oe_set  <= 32'h0000_FFFF;
        gpio_out_set <= 32'h1234_5678;
        pullup_clr   <= 32'hFFFF_0000;
        ext_en       <= 32'hFFFF_0000;
        ext_drive    <= 32'hC3A5_0000;
        cfg(32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
        settle(5);
        check("status", peripheral_select_status, 32'h0000_0000);
        check("oe_n", pad_oe_n, 32'hFFFF_0000);
        check("pad", pad_out & 32'h0000_FFFF, 32'h0000_5678);
        check("pullup", pad_pullup_en, 32'h0000_FFFF);
        check("gpio_oe", gpio_oe_status, 32'h0000_FFFF);
        check("gpio_out", gpio_out_status, 32'h1234_5678);
        check("level", line_level, 32'hC3A5_5678);
        @(posedge clk);
        ce <= 1'b0;
        gpio_out_clr <= 32'hFFFF_FFFF;
        settle(3);
        check("frozen", pad_out & 32'h0000_FFFF, 32'h0000_5678);
        @(posedge clk);
        gpio_out_clr <= '0;
        ce <= 1'b1;
        ext_en <= '0;
        $display("test gpio done, mismatches %0d", mismatches);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 2000)
        begin
            mismatches++;
            complete_run();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        ce = 1'b1;
        {periph_set, periph_clr, func_b_set, func_a_set, pullup_set, pullup_clr} = '0;
        {gpio_oe_set, gpio_oe_clr, gpio_out_set, gpio_out_clr} = '0;
        {func_a_out, func_a_oe, func_b_out, func_b_oe, ext_drive, ext_en} = '0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        t_reset();
        t_func_a();
        t_func_b();
        t_fanout();
        t_gpio();
        t_reset();
        complete_run();
    end
endmodule
